// ==== verilog/ppc_port_ctrl.sv ====
/*
 * Parallel port controller: seven ports behind an APB slave, per-line
 * output latch, direction, open-drain, alternate claim and pad control.
 * Assumes a pad ring that resolves level and active-low enable per pin,
 * and peripherals that present alternate values and drive enables.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.svh"

module ppc_port_ctrl (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire ppc_pkg::ppc_port_vec_type pin_in,
    output ppc_pkg::ppc_port_vec_type pin_level_out,
    output ppc_pkg::ppc_port_vec_type pin_oe_n_out,
    input wire ppc_pkg::ppc_port_vec_type alt_out_in,
    input wire ppc_pkg::ppc_port_vec_type alt_oe_in,
    output ppc_pkg::ppc_port_vec_type alt_in_out,
    output ppc_pkg::ppc_pad_cfg_arr_type pad_cfg_out
);
    import ppc_pkg::*;

    localparam ppc_port_vec_type LINE_MASK = `PPC_LINE_MASK;
    localparam logic [6:0] CAP_OD = `PPC_CAP_OD;
    localparam logic [6:0] CAP_THR = `PPC_CAP_THR;
    localparam logic [6:0] CAP_PAD = `PPC_CAP_PAD;
    localparam logic [6:0] CAP_INONLY = `PPC_CAP_INONLY;

    // ************************************************************
    // apb decode
    // ************************************************************
    logic [2:0] port_idx;
    logic [2:0] reg_idx;
    logic addr_ok;
    logic wr_en;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic [31:0] prdata_reg;

    assign port_idx = paddr_in[7:5];
    assign reg_idx = paddr_in[4:2];
    // window 7 and anything above the port windows is unmapped
    assign addr_ok = (paddr_in[11:8] == `PPC_ADDR_HI_ZERO) &&
        (port_idx <= `PPC_PORT_LAST);
    assign wr_en = psel_in && penable_in && pwrite_in && addr_ok;
    assign wmask = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
    assign wdata = pwdata_in[15:0];
    // read data is captured in the setup cycle, so no wait state is needed
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !addr_ok;
    assign prdata_out = prdata_reg;

    // ************************************************************
    // per-port software state
    // ************************************************************
    logic [15:0] out_reg [`PPC_NUM_PORTS];
    logic [15:0] dir_reg [`PPC_NUM_PORTS];
    logic [15:0] od_reg [`PPC_NUM_PORTS];
    logic [15:0] alt_reg [`PPC_NUM_PORTS];
    ppc_pad_cfg_type cfg_reg [`PPC_NUM_PORTS];
    ppc_port_vec_type sync_pins;
    ppc_port_vec_type level_next;
    ppc_port_vec_type oe_n_next;
    logic rst_done_reg;

    genvar p;
    generate
        for (p = 0; p < `PPC_NUM_PORTS; p = p + 1)
        begin : g_port
            logic hit;
            logic [15:0] wm;
            logic [15:0] drive;
            logic [15:0] val;
            logic [15:0] odm;
            logic [15:0] force_in;

            assign hit = wr_en && (port_idx == 3'(p));
            assign wm = wmask & LINE_MASK[p];

            // output latch: whole write, or set and clear of single lines
            always_ff @(posedge clk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                    out_reg[p] <= `PPC_RST_LINES;
                else if (hit && reg_idx == `PPC_REG_OUT)
                    out_reg[p] <= (out_reg[p] & ~wm) | (wdata & wm);
                else if (hit && reg_idx == `PPC_REG_SET)
                    out_reg[p] <= out_reg[p] | (wdata & wm); // RL2
                else if (hit && reg_idx == `PPC_REG_CLR)
                    out_reg[p] <= out_reg[p] & ~(wdata & wm); // RL2
            end

            // direction, one bit per line; the input-only port ignores writes
            always_ff @(posedge clk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                    dir_reg[p] <= `PPC_RST_LINES; // RL6
                else if (hit && reg_idx == `PPC_REG_DIR && !CAP_INONLY[p])
                    dir_reg[p] <= (dir_reg[p] & ~wm) | (wdata & wm); // RL3
            end

            // open-drain selection exists only on ports that offer it
            always_ff @(posedge clk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                    od_reg[p] <= `PPC_RST_LINES;
                else if (hit && reg_idx == `PPC_REG_OD && CAP_OD[p])
                    od_reg[p] <= (od_reg[p] & ~wm) | (wdata & wm); // RL5
            end

            // alternate function claim per line
            always_ff @(posedge clk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                    alt_reg[p] <= `PPC_RST_LINES;
                else if (hit && reg_idx == `PPC_REG_ALT)
                    alt_reg[p] <= (alt_reg[p] & ~wm) | (wdata & wm); // RL9
            end

            // pad driver control, threshold only where the port has it
            always_ff @(posedge clk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                    cfg_reg[p] <= `PPC_RST_CFG;
                else if (hit && reg_idx == `PPC_REG_CFG && pstrb_in[0] && CAP_PAD[p])
                begin
                    cfg_reg[p].edge_sel <= pwdata_in[1:0]; // RL7
                    cfg_reg[p].current <= pwdata_in[3:2]; // RL7
                    cfg_reg[p].thresh_cmos <= CAP_THR[p] ? pwdata_in[5:4] : 2'h0; // RL8 RL10
                end
            end

            // the external access enable line of the bus-control port is an input
            assign force_in = (p == `PPC_BUS_PORT_IDX) ? 16'(1 << `PPC_EA_BIT) : 16'h0000;
            // an alternate function takes both value and drive of its line
            assign drive = CAP_INONLY[p] ? 16'h0000 :
                ((alt_reg[p] & alt_oe_in[p] & {16{rst_done_reg}}) |
                (~alt_reg[p] & dir_reg[p])) &
                LINE_MASK[p] & ~force_in; // RL1 RL3 RL9
            assign val = (alt_reg[p] & alt_out_in[p]) |
                (~alt_reg[p] & out_reg[p]); // RL9 RL11
            assign odm = od_reg[p];

            // open-drain lines drive only low and release for a high
            always_comb
            begin
                level_next[p] = val & ~odm & LINE_MASK[p]; // RL5 RL11
                oe_n_next[p] = ~(drive & ~(odm & val)); // RL4 RL5
                if (p == `PPC_BUS_PORT_IDX)
                begin
                    // reset indication follows reset, never floats in push-pull
                    level_next[p][`PPC_RSTIND_BIT] = 1'b1 & ~odm[`PPC_RSTIND_BIT];
                    oe_n_next[p][`PPC_RSTIND_BIT] = odm[`PPC_RSTIND_BIT]; // RL10
                end
            end

            assign pad_cfg_out[p] = cfg_reg[p];
            assign alt_in_out[p] = sync_pins[p] & LINE_MASK[p]; // RL9
        end
    endgenerate

    // ************************************************************
    // pin input path
    // ************************************************************
    ppc_pin_sync #(
        .WIDTH(`PPC_NUM_PORTS * `PPC_PORT_BITS)
    ) u_sync (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .raw_in(pin_in),
        .sync_out(sync_pins)
    );

    // ************************************************************
    // pin output stage
    // ************************************************************
    ppc_port_vec_type pin_level_reg;
    ppc_port_vec_type pin_oe_n_reg;

    // marks the first edge after reset release; keeps alternate drivers off until then
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rst_done_reg <= 1'b0;
        else
            rst_done_reg <= 1'b1;
    end

    // registered pins: under reset every line floats except reset indication,
    // which is driven low
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pin_level_reg <= '0; // RL6
            pin_oe_n_reg <= ~(112'(1) << (`PPC_BUS_PORT_IDX * 16 + `PPC_RSTIND_BIT)); // RL6
        end
        else
        begin
            pin_level_reg <= level_next; // RL11
            pin_oe_n_reg <= oe_n_next; // RL4
        end
    end

    assign pin_level_out = pin_level_reg;
    assign pin_oe_n_out = pin_oe_n_reg;

    // ************************************************************
    // read path
    // ************************************************************
    logic [15:0] sel_out;
    logic [15:0] sel_dir;

    assign sel_out = (port_idx <= `PPC_PORT_LAST) ? out_reg[port_idx] : 16'h0000;
    assign sel_dir = (port_idx <= `PPC_PORT_LAST) ? dir_reg[port_idx] : 16'h0000;

    // unmapped reads and set/clear windows return zero
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            prdata_reg <= 32'h0000_0000;
        else if (psel_in && !penable_in)
        begin
            prdata_reg <= 32'h0000_0000;
            if (addr_ok)
            begin
                case (reg_idx)
                    `PPC_REG_OUT: prdata_reg <= {16'h0000, sel_out};
                    `PPC_REG_DIR: prdata_reg <= {16'h0000, sel_dir};
                    `PPC_REG_OD: prdata_reg <= {16'h0000, od_reg[port_idx]};
                    `PPC_REG_IN: prdata_reg <= {16'h0000, sync_pins[port_idx] &
                        LINE_MASK[port_idx]};
                    `PPC_REG_ALT: prdata_reg <= {16'h0000, alt_reg[port_idx]};
                    `PPC_REG_CFG: prdata_reg <= {26'h0, cfg_reg[port_idx]};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    logic set_hit;
    logic dir_hit;
    logic [15:0] set_val;
    logic [15:0] dir_val;

    assign set_hit = wr_en && reg_idx == `PPC_REG_SET;
    assign dir_hit = wr_en && reg_idx == `PPC_REG_DIR;
    assign set_val = sel_out | (wdata & wmask & LINE_MASK[port_idx]);
    assign dir_val = CAP_INONLY[port_idx] ? sel_dir :
        ((sel_dir & ~(wmask & LINE_MASK[port_idx])) | (wdata & wmask & LINE_MASK[port_idx]));

    property p_inonly_float;
        pin_oe_n_out[4] == 16'hFFFF;
    endproperty
    a_inonly_float: assert property (p_inonly_float) else $error("input-only port driven"); // RL1

    property p_set_bits;
        set_hit |=>
            out_reg[$past(port_idx)] == $past(set_val);
    endproperty
    a_set_bits: assert property (p_set_bits) else $error("set write disturbed latch"); // RL2

    property p_dir_write;
        dir_hit |=>
            dir_reg[$past(port_idx)] == $past(dir_val);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write wrong"); // RL3

    property p_input_floats;
        (dir_reg[0] == 16'h0000 && alt_reg[0] == 16'h0000) |=>
            pin_oe_n_out[0] == 16'hFFFF;
    endproperty
    a_input_floats: assert property (p_input_floats) else $error("input line driven"); // RL4

    property p_od_release;
        (dir_reg[6][0] && od_reg[6][0] && !alt_reg[6][0] && out_reg[6][0])
            |=> (pin_oe_n_out[6][0] && !pin_level_out[6][0]);
    endproperty
    a_od_release: assert property (p_od_release) else $error("open-drain high driven"); // RL5

    property p_reset_pins;
        disable iff (1'b0)
        !arst_n_in |-> (pin_oe_n_out[0] == 16'hFFFF && !pin_oe_n_out[6][4] &&
            !pin_level_out[6][4]);
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pins wrong in reset"); // RL6

    property p_pad_none;
        pad_cfg_out[4] == 6'h00;
    endproperty
    a_pad_none: assert property (p_pad_none) else $error("pad control on port without it"); // RL7

    property p_thr_none;
        pad_cfg_out[0].thresh_cmos == 2'h0 &&
        pad_cfg_out[1].thresh_cmos == 2'h0;
    endproperty
    a_thr_none: assert property (p_thr_none) else $error("threshold on port without it"); // RL8

    property p_alt_drive;
        (alt_reg[2][0] && alt_oe_in[2][0])
            |=> (!pin_oe_n_out[2][0] && pin_level_out[2][0] == $past(alt_out_in[2][0]));
    endproperty
    a_alt_drive: assert property (p_alt_drive) else $error("alternate value not driven"); // RL9

    property p_bus_port;
        pad_cfg_out[6].thresh_cmos == 2'h0 &&
        pin_oe_n_out[6][3];
    endproperty
    a_bus_port: assert property (p_bus_port) else $error("bus port setup wrong"); // RL10

    property p_sw_drive;
        (dir_reg[0][1] && !alt_reg[0][1])
            |=> (!pin_oe_n_out[0][1] && pin_level_out[0][1] == $past(out_reg[0][1]));
    endproperty
    a_sw_drive: assert property (p_sw_drive) else $error("latched value not driven"); // RL11

    // scenarios that the bench is meant to reach
    c_set_write: cover property (set_hit);
    c_alt_claim: cover property (alt_reg[2][0] && alt_oe_in[2][0] ##1 !pin_oe_n_out[2][0]);
    c_od_release: cover property (od_reg[6][0] && dir_reg[6][0] && out_reg[6][0]);
    c_bus_error: cover property (pslverr_out);
endmodule

`default_nettype wire

// ==== verilog/ppc_defines.svh ====
/*
 * Constants of the parallel port block: register offsets, reset values,
 * per-port line masks and per-port feature masks.
 * Assumes it is included by bare name into the package and the modules.
 */
//
// Functional notes
// [RL1] seventy-nine lines: six bidirectional ports, one input-only
// [RL2] single lines changed through set and clear
// [RL3] one direction bit per bidirectional line
// [RL4] input lines release the pin driver
// [RL5] per-pin push-pull or open-drain where offered
// [RL6] reset makes all pins inputs, except reset indication
// [RL7] pad driver control selects edge and current
// [RL8] threshold type chosen per byte where offered
// [RL9] alternate function claims line, else software port
// [RL10] bus-control port: pad and open-drain, no threshold
// [RL11] software output drives the last latched value
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH

// ************************************************************
// register window layout
// ************************************************************
`define PPC_NUM_PORTS 7
`define PPC_PORT_BITS 16
`define PPC_REG_OUT 3'h0
`define PPC_REG_DIR 3'h1
`define PPC_REG_OD 3'h2
`define PPC_REG_IN 3'h3
`define PPC_REG_SET 3'h4
`define PPC_REG_CLR 3'h5
`define PPC_REG_ALT 3'h6
`define PPC_REG_CFG 3'h7
`define PPC_PORT_LAST 3'h6
`define PPC_ADDR_HI_ZERO 4'h0

// ************************************************************
// reset values
// ************************************************************
`define PPC_RST_LINES 16'h0000
`define PPC_RST_CFG 6'h00

// ************************************************************
// port shapes: index 0..6 = P0, P1, P3, P4, P5, P9, P20
// ************************************************************
`define PPC_LINE_MASK {16'h001F, 16'h001F, 16'h3FFF, 16'h00FF, 16'h7FFF, 16'hFFFF, 16'hFFFF}
`define PPC_CAP_OD 7'h6C
`define PPC_CAP_THR 7'h2C
`define PPC_CAP_PAD 7'h6F
`define PPC_CAP_INONLY 7'h10
`define PPC_BUS_PORT_IDX 6
`define PPC_EA_BIT 3
`define PPC_RSTIND_BIT 4

`endif

// ==== verilog/ppc_pkg.sv ====
/*
 * Types of the parallel port block.
 * Assumes ppc_defines.svh is on the include path.
 */
`include "ppc_defines.svh"

package ppc_pkg;
    // ************************************************************
    // carriers
    // ************************************************************
    // all ports side by side; unused upper lines are zero on levels and one on active-low enables
    typedef logic [`PPC_NUM_PORTS-1:0][`PPC_PORT_BITS-1:0] ppc_port_vec_type;

    // pad control of one port
    typedef struct packed {
        logic [1:0] thresh_cmos; // bit 0 low byte, bit 1 high byte
        logic [1:0] current;
        logic [1:0] edge_sel;
    } ppc_pad_cfg_type;

    typedef ppc_pad_cfg_type [`PPC_NUM_PORTS-1:0] ppc_pad_cfg_arr_type;
endpackage

// ==== verilog/ppc_pin_sync.sv ====
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes raw pin levels asynchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module ppc_pin_sync #(
    parameter int WIDTH = 112
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] raw_in,
    output logic [WIDTH-1:0] sync_out
);
    // ************************************************************
    // stages
    // ************************************************************
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] val_reg;

    // first stage feeds only the second
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end
        else
        begin
            s1_reg <= raw_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a bit clears while the two later stages differ and follows them once they agree, so only a high glitch is dropped
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            val_reg <= '0;
        else
            val_reg <= (val_reg & ~(s2_reg ^ s3_reg)) | (s3_reg & ~(s2_reg ^ s3_reg));
    end

    assign sync_out = val_reg;
endmodule

`default_nettype wire

// ==== test/ppc_board_model.sv ====
/*
 * Board model of the pins: a pull-up on every line and an external
 * driver that the bench switches on line by line.
 * Assumes active-low pin enables from the port block.
 */
`timescale 1ns/1ps
`default_nettype none

module ppc_board_model (
    input wire ppc_pkg::ppc_port_vec_type level_in,
    input wire ppc_pkg::ppc_port_vec_type oe_n_in,
    input wire ppc_pkg::ppc_port_vec_type ext_en_in,
    input wire ppc_pkg::ppc_port_vec_type ext_val_in,
    output ppc_pkg::ppc_port_vec_type pin_out
);
    import ppc_pkg::*;
    // ************************************************************
    // wire resolution
    // ************************************************************
    // device wins where it drives; the bench never fights a driven pin,
    // so a released line shows the board driver or else the pull-up
    assign pin_out = (~oe_n_in & level_in) | (oe_n_in & ext_en_in & ext_val_in)
        | (oe_n_in & ~ext_en_in);
endmodule
`default_nettype wire

// ==== test/tb_parallel_port_control.sv ====
/*
 * Self-checking bench of the parallel port block: APB master tasks,
 * one task per scenario, board model on the pins.
 * Assumes ppc_defines.svh on the include path; assertions live in the design.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.svh"

module tb_parallel_port_control;
    import ppc_pkg::*;
    localparam int CYCLE_LIMIT = 5000;
    localparam ppc_port_vec_type LINE_MASK = `PPC_LINE_MASK;
    localparam logic [6:0] CAP_PAD = `PPC_CAP_PAD;
    localparam logic [6:0] CAP_THR = `PPC_CAP_THR;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [3:0] pstrb_in = 4'hF;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    ppc_port_vec_type pin_in;
    ppc_port_vec_type pin_level_out;
    ppc_port_vec_type pin_oe_n_out;
    ppc_port_vec_type alt_out_in = '0;
    ppc_port_vec_type alt_oe_in = '0;
    ppc_port_vec_type alt_in_out;
    ppc_pad_cfg_arr_type pad_cfg_out;
    ppc_port_vec_type ext_en = '0;
    ppc_port_vec_type ext_val = '0;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;

    ppc_port_ctrl uut (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .pin_in(pin_in),
        .pin_level_out(pin_level_out), .pin_oe_n_out(pin_oe_n_out),
        .alt_out_in(alt_out_in), .alt_oe_in(alt_oe_in), .alt_in_out(alt_in_out),
        .pad_cfg_out(pad_cfg_out)
    );

    ppc_board_model board (
        .level_in(pin_level_out), .oe_n_in(pin_oe_n_out), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .pin_out(pin_in)
    );

    // 200 MHz clock; the cycle ceiling cuts a hung run short
    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == CYCLE_LIMIT)
        begin
            n_fail++;
            end_of_test();
        end
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic end_of_test();
        $display("TB: %0d mismatches in %0d comparisons", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one transfer: setup, access until pready, then one idle edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [15:0] wdata,
        output logic [15:0] rdata, output logic err);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= {16'h0, wdata};
        @(posedge clk_in);
        penable_in <= 1'b1;
        do
        begin
            @(posedge clk_in);
        end
        while (pready_out !== 1'b1);
        check({15'h0, pready_out}, 16'h0001, "bus answer");
        rdata = prdata_out[15:0];
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask

    function automatic logic [11:0] ra(input int p, input logic [2:0] r);
        return 12'(p * 32) | {7'h0, r, 2'b00};
    endfunction

    task automatic wr(input int p, input logic [2:0] r, input logic [15:0] d);
        logic [15:0] q;
        logic e;
        apb(1'b1, ra(p, r), d, q, e);
        check({15'h0, e}, 16'h0000, "write error flag");
    endtask

    task automatic rd(input int p, input logic [2:0] r, input logic [15:0] exp,
        input string what);
        logic [15:0] q;
        logic e;
        apb(1'b0, ra(p, r), 16'h0, q, e);
        check(q, exp, what);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset_pins();
        for (int p = 0; p < 7; p++)
            check(pin_oe_n_out[p], (p == 6) ? 16'hFFEF : 16'hFFFF, "reset dir");
        check({15'h0, pin_level_out[6][4]}, 16'h0000, "reset indication low");
    endtask

    task automatic t_released();
        check(pin_oe_n_out[6], 16'hFFEF, "indication driven");
        check(pin_level_out[6], 16'h0010, "indication high");
    endtask

    task automatic t_regs_reset();
        logic [2:0] regs [5] = '{`PPC_REG_OUT, `PPC_REG_DIR, `PPC_REG_OD, `PPC_REG_ALT,
            `PPC_REG_CFG};
        for (int p = 0; p < 7; p++)
            foreach (regs[i])
                rd(p, regs[i], 16'h0000, "register reset value");
    endtask

    task automatic t_dir_out();
        wr(1, `PPC_REG_OUT, 16'h5AC3);
        wr(1, `PPC_REG_DIR, 16'h0F0F);
        ext_en[1] <= 16'hF0F0;
        ext_val[1] <= 16'hA500;
        repeat (8) @(posedge clk_in);
        check(pin_oe_n_out[1], 16'hF0F0, "per-line direction");
        check(pin_level_out[1] & 16'h0F0F, 16'h0A03, "latch on pins");
        rd(1, `PPC_REG_IN, 16'hAA03, "pin readback");
        check(alt_in_out[1], 16'hAA03, "pins to peripherals");
        wr(1, `PPC_REG_IN, 16'h0000);
        wr(1, `PPC_REG_SET, 16'h0004);
        wr(1, `PPC_REG_CLR, 16'h0001);
        rd(1, `PPC_REG_OUT, 16'h5AC6, "single-line set and clear");
        repeat (8) @(posedge clk_in);
        check(pin_level_out[1] & 16'h0F0F, 16'h0A06, "single lines on pins");
        rd(1, `PPC_REG_IN, 16'hAA06, "input register read only");
        ext_en[1] <= 16'h0000;
        wr(1, `PPC_REG_DIR, 16'h0000);
    endtask

    task automatic t_open_drain();
        wr(6, `PPC_REG_DIR, 16'h0001);
        wr(6, `PPC_REG_OUT, 16'h0001);
        wr(6, `PPC_REG_OD, 16'h0001);
        repeat (2) @(posedge clk_in);
        check(pin_oe_n_out[6], 16'hFFEF, "open-drain high released");
        wr(6, `PPC_REG_CLR, 16'h0001);
        repeat (2) @(posedge clk_in);
        check(pin_oe_n_out[6], 16'hFFEE, "open-drain low driven");
        check(pin_level_out[6], 16'h0010, "open-drain low level");
        wr(6, `PPC_REG_SET, 16'h0001);
        wr(6, `PPC_REG_OD, 16'h0010);
        rd(6, `PPC_REG_OD, 16'h0010, "open-drain setting");
        check(pin_oe_n_out[6], 16'hFFFE, "push-pull");
        check(pin_level_out[6] & 16'h0001, 16'h0001, "push-pull high");
        wr(1, `PPC_REG_OD, 16'hFFFF);
        rd(1, `PPC_REG_OD, 16'h0000, "no open-drain here");
        wr(6, `PPC_REG_OD, 16'h0000);
        wr(6, `PPC_REG_DIR, 16'h0000);
    endtask

    task automatic t_input_only();
        logic [15:0] exp;
        for (int p = 0; p < 7; p++)
            wr(p, `PPC_REG_DIR, 16'hFFFF);
        repeat (2) @(posedge clk_in);
        for (int p = 0; p < 7; p++)
        begin
            exp = (p == 4) ? 16'hFFFF : ~LINE_MASK[p] | ((p == 6) ? 16'h0008 : 16'h0000);
            check(pin_oe_n_out[p], exp, "port shape");
            wr(p, `PPC_REG_DIR, 16'h0000);
        end
        rd(3, `PPC_REG_DIR, 16'h0000, "direction cleared");
    endtask

    task automatic t_pad_cfg();
        logic [5:0] vals [2] = '{6'h3F, 6'h25};
        logic [5:0] m;
        foreach (vals[v])
        begin
            for (int p = 0; p < 7; p++)
                wr(p, `PPC_REG_CFG, {10'h0, vals[v]});
            repeat (2) @(posedge clk_in);
            for (int p = 0; p < 7; p++)
            begin
                m = CAP_PAD[p] ? (CAP_THR[p] ? 6'h3F : 6'h0F) : 6'h00;
                check({10'h0, pad_cfg_out[p]}, {10'h0, vals[v] & m}, "pad pins");
                rd(p, `PPC_REG_CFG, {10'h0, vals[v] & m}, "pad setting");
            end
        end
    endtask

    task automatic t_alt();
        alt_oe_in[2] <= 16'h000F;
        alt_out_in[2] <= 16'h0005;
        wr(2, `PPC_REG_OUT, 16'hFFFF);
        wr(2, `PPC_REG_DIR, 16'hFFF0);
        wr(2, `PPC_REG_ALT, 16'h00FF);
        repeat (8) @(posedge clk_in);
        check(pin_oe_n_out[2], 16'h80F0, "claimed drive");
        check(pin_level_out[2] & 16'h7F0F, 16'h7F05, "claimed and free values");
        check(alt_in_out[2] & 16'h00FF, 16'h00F5, "claimed lines read back");
        alt_oe_in[2] <= 16'h0000;
        wr(2, `PPC_REG_ALT, 16'h0000);
        wr(2, `PPC_REG_DIR, 16'h0000);
    endtask

    task automatic t_unmapped();
        logic [15:0] q;
        logic e;
        apb(1'b1, 12'h0E0, 16'hFFFF, q, e);
        check({15'h0, e}, 16'h0001, "error on empty window");
        apb(1'b0, 12'h104, 16'h0, q, e);
        check({15'h0, e}, 16'h0001, "error on high address");
        check(q, 16'h0000, "unmapped read data");
        rd(0, `PPC_REG_OUT, 16'h0000, "latch after refused write");
    endtask

    task automatic t_mid_reset();
        wr(0, `PPC_REG_DIR, 16'h00FF);
        repeat (2) @(posedge clk_in);
        check(pin_oe_n_out[0], 16'hFF00, "outputs before reset");
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        t_reset_pins();
        arst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        t_released();
        rd(0, `PPC_REG_DIR, 16'h0000, "direction after reset");
    endtask

    // main sequence: reset held for 10 cycles, then every scenario in turn
    initial
    begin
        arst_n_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        t_reset_pins();
        arst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        t_released();
        t_regs_reset();
        t_dir_out();
        t_open_drain();
        t_input_only();
        t_pad_cfg();
        t_alt();
        t_unmapped();
        t_mid_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
